// *** design/dec_alu.v ***
// combinational decrement and decimal-adjust arithmetic
`timescale 1ns/100ps
`include "dec_exec_map.vh"
module dec_alu (
    input  wire [7:0] opnd,      // byte read in q2
    input  wire       sel_adj,   // high for decimal adjust
    input  wire       c_in,      // current carry flag
    input  wire       nib_c_in,  // current digit carry flag
    output reg  [7:0] res,       // result byte
    output reg        c_out,     // new carry
    output reg        nib_c_out, // new digit carry
    output reg        ovf_out,   // new overflow
    output reg        n_out,     // new negative
    output reg        z_out      // new zero
);
    reg [4:0] lo;
    reg [4:0] hi;
    // ---------------------------------------------------------------
    // arithmetic
    // ---------------------------------------------------------------
    // decrement as add of two's complement so carry means no borrow
    always @* begin
        lo = 5'h00;
        hi = 5'h00;
        res = 8'h00;
        c_out = c_in;
        nib_c_out = nib_c_in;
        ovf_out = 1'b0;
        if (sel_adj) begin
            if (opnd[3:0] > `BCD_NINE || nib_c_in) begin // RULE8
                lo = {1'b0, opnd[3:0]} + {1'b0, `BCD_SIX};
            end else begin
                lo = {1'b0, opnd[3:0]};
            end
            // low-nibble overflow propagates into the high nibble
            hi = {1'b0, opnd[7:4]} + {4'h0, lo[4]};
            if (hi > {1'b0, `BCD_NINE} || c_in) begin // RULE9
                hi = hi + {1'b0, `BCD_SIX};
                c_out = 1'b1;
            end else if (hi[4]) begin
                c_out = 1'b1;
            end
            res = {hi[3:0], lo[3:0]};
        end else begin
            // RULE1
            res = opnd - `DEC_ONE;
            c_out = (opnd != 8'h00);
            nib_c_out = (opnd[3:0] != 4'h0);
            ovf_out = (opnd == 8'h80);
        end
        n_out = res[7];
        z_out = (res == 8'h00);
    end
endmodule

// *** design/decrement_file_register_exec.v ***
// execution unit for byte decrement and decimal adjust of working register
//
// Function
// (RULE1) subtract one from addressed byte; update carry, digit carry, negative, overflow, zero
// (RULE2) destination bit clear: result to working register, memory untouched
// (RULE3) destination bit set: result written back to the same location
// (RULE4) access bit clear: address resolved within the fixed access bank
// (RULE5) access bit set: bank selection register picks the memory bank
// (RULE6) access clear, extended set on, address at or below 5fh: indexed literal
// (RULE7) decode 000001 d a f opcode; q1 decode, q2 read, q3 process, q4 write
// (RULE8) decimal adjust: low nibble plus six if above nine or digit carry
// (RULE9) decimal adjust: high nibble plus six, carry set, if above nine or carry
`timescale 1ns/100ps
`include "dec_exec_map.vh"
module decrement_file_register_exec #(
    parameter ADDR_W = 12             // data memory address width
) (
    input  wire              core_clk,        // core clock
    input  wire              sys_rst,         // sync reset, active high
    input  wire              instr_valid,     // new instruction word offered in q1
    input  wire [15:0]       instr_word,      // instruction word
    input  wire [3:0]        bank_selection_register, // bank for banked access
    input  wire              ext_instr_en,    // extended instruction set enabled
    input  wire [ADDR_W-1:0] index_base,      // index pointer for literal offsets
    input  wire [7:0]        wreg_in,         // working register current value
    input  wire [7:0]        status_c_in,     // unused high bits zero; bit0 carry
    input  wire              digit_carry_flag_in, // current digit carry
    input  wire [7:0]        mem_rdata,       // data memory read data
    output reg  [ADDR_W-1:0] mem_addr,        // data memory address
    output reg               mem_rd,          // read strobe in q2
    output reg               mem_wr,          // write strobe in the q1 after q4
    output reg  [7:0]        mem_wdata,       // write data
    output reg               wreg_wr,         // working register write strobe
    output reg  [7:0]        wreg_wdata,      // working register new value
    output reg               flags_wr,        // flag update strobe
    output reg               carry_flag,      // new carry
    output reg               digit_carry_flag, // new digit carry
    output reg               negative_flag,   // new negative
    output reg               overflow_flag,   // new overflow
    output reg               zero_flag,       // new zero
    output reg               busy             // high from q2 to q4
);
    // ---------------------------------------------------------------
    // state and latches
    // ---------------------------------------------------------------
    reg [`Q_BITS-1:0] q_q;
    reg               is_dec_q;
    reg               is_adj_q;
    reg               dest_q;
    reg [7:0]         opnd_q;
    reg [7:0]         res_q;
    reg               c_q;
    reg               nib_c_q;
    reg               n_q;
    reg               ovf_q;
    reg               z_q;

    // one-hot phase codes of the instruction cycle
    localparam [`Q_BITS-1:0] ST_Q1 = `Q1_ST; // decode
    localparam [`Q_BITS-1:0] ST_Q2 = `Q2_ST; // read
    localparam [`Q_BITS-1:0] ST_Q3 = `Q3_ST; // process
    localparam [`Q_BITS-1:0] ST_Q4 = `Q4_ST; // write

    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_nib_c;
    wire       alu_ovf;
    wire       alu_n;
    wire       alu_z;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire dec_hit = (instr_word[`OPC_TOP_HI:`OPC_TOP_LO] == `OPC_DEC_TOP); // RULE7
    wire adj_hit = (instr_word == `OPC_ADJ_WORD);
    wire [7:0] f_ad = instr_word[7:0];
    wire acc_bit = instr_word[`OPC_ACC_BIT];
    // a recognised instruction is in flight; gates the working-register data and flag write-back
    wire do_exec = is_dec_q | is_adj_q;

    // address formation, combinational from the offered word
    reg [ADDR_W-1:0] ea;
    always @* begin
        ea = {ADDR_W{1'b0}};
        if (acc_bit) begin
            ea = {bank_selection_register, f_ad}; // RULE5
        end else if (ext_instr_en && f_ad <= `LIT_OFS_LIMIT) begin
            ea = index_base + {{(ADDR_W-8){1'b0}}, f_ad}; // RULE6
        end else if (f_ad < `ACC_HI_SPLIT) begin
            ea = {`ACC_BANK_LO, f_ad}; // RULE4
        end else begin
            ea = {`ACC_BANK_HI, f_ad}; // RULE4
        end
    end

    // ---------------------------------------------------------------
    // arithmetic instance
    // ---------------------------------------------------------------
    dec_alu u_alu (
        .opnd   (opnd_q),
        .sel_adj  (is_adj_q),
        .c_in     (status_c_in[0]),
        .nib_c_in (digit_carry_flag_in),
        .res      (alu_res),
        .c_out    (alu_c),
        .nib_c_out(alu_nib_c),
        .ovf_out  (alu_ovf),
        .n_out  (alu_n),
        .z_out  (alu_z)
    );

    // ---------------------------------------------------------------
    // quarter-cycle sequencer
    // ---------------------------------------------------------------
    // free-running ring, one instruction per four core clocks; words are
    // only looked at in q1, so an offer made later simply waits its turn
    always @(posedge core_clk) begin
        if (sys_rst) begin
            q_q <= ST_Q1;
        end else begin
            case (q_q)
                ST_Q1: begin
                    q_q <= ST_Q2; // RULE7
                end
                ST_Q2: begin
                    q_q <= ST_Q3;
                end
                ST_Q3: begin
                    q_q <= ST_Q4;
                end
                ST_Q4: begin
                    q_q <= ST_Q1;
                end
                default: begin
                    // a corrupted ring restarts at decode
                    q_q <= ST_Q1;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // decode latches, q1
    // ---------------------------------------------------------------
    // the kind of instruction is kept for the whole cycle so that a word
    // changing after q1 cannot disturb the later phases
    always @(posedge core_clk) begin
        if (sys_rst) begin
            is_dec_q <= 1'b0;
            is_adj_q <= 1'b0;
            dest_q   <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_rd   <= 1'b0;
            busy     <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            if (q_q == ST_Q1) begin
                is_dec_q <= instr_valid & dec_hit; // RULE7
                is_adj_q <= instr_valid & adj_hit;
                dest_q   <= instr_word[`OPC_DEST_BIT];
                mem_addr <= ea;
                mem_rd   <= instr_valid & dec_hit;
                busy     <= instr_valid & (dec_hit | adj_hit);
            end else if (q_q == ST_Q4) begin
                busy <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // operand capture, q2, and result latch, q3
    // ---------------------------------------------------------------
    // memory data must stand while the read strobe is high; it is taken
    // at the edge that ends the strobe, so no extra wait state is needed
    always @(posedge core_clk) begin
        if (sys_rst) begin
            opnd_q <= 8'h00;
            res_q  <= 8'h00;
            {c_q, nib_c_q, n_q, ovf_q, z_q} <= 5'h00;
        end else if (q_q == ST_Q2) begin
            opnd_q <= is_adj_q ? wreg_in : mem_rdata;
        end else if (q_q == ST_Q3) begin
            res_q <= alu_res;
            {c_q, nib_c_q, n_q, ovf_q, z_q} <= {alu_c, alu_nib_c, alu_n, alu_ovf, alu_z};
        end
    end

    // ---------------------------------------------------------------
    // write-back, q4
    // ---------------------------------------------------------------
    // strobes last one clock; data and flags move only with a strobe, so
    // a refused word leaves every output but mem_addr as it was
    always @(posedge core_clk) begin
        if (sys_rst) begin
            mem_wr     <= 1'b0;
            mem_wdata  <= 8'h00;
            wreg_wr    <= 1'b0;
            wreg_wdata <= 8'h00;
            flags_wr   <= 1'b0;
            {carry_flag, digit_carry_flag, negative_flag} <= 3'h0;
            {overflow_flag, zero_flag} <= 2'h0;
        end else begin
            mem_wr   <= 1'b0;
            wreg_wr  <= 1'b0;
            flags_wr <= 1'b0;
            if (q_q == ST_Q4 && is_dec_q) begin
                mem_wr    <= dest_q; // RULE3
                mem_wdata <= res_q; // RULE3
                wreg_wr   <= ~dest_q; // RULE2
            end
            if (q_q == ST_Q4 && is_adj_q) begin
                wreg_wr <= 1'b1; // RULE8
            end
            if (q_q == ST_Q4 && do_exec) begin
                wreg_wdata       <= res_q;
                flags_wr         <= 1'b1; // RULE1
                carry_flag       <= c_q;
                digit_carry_flag <= nib_c_q;
                negative_flag    <= n_q;
                overflow_flag    <= ovf_q;
                zero_flag        <= z_q;
            end
        end
    end
endmodule

// *** shared/dec_exec_map.vh ***
// constants for the decrement and decimal-adjust execution block
`ifndef DEC_EXEC_MAP_VH
`define DEC_EXEC_MAP_VH
// ---------------------------------------------------------------
// opcode fields
// ---------------------------------------------------------------
`define OPC_DEC_TOP      6'h01
`define OPC_ADJ_WORD     16'h0007
`define OPC_TOP_HI       15
`define OPC_TOP_LO       10
`define OPC_DEST_BIT     9
`define OPC_ACC_BIT      8
// ---------------------------------------------------------------
// addressing
// ---------------------------------------------------------------
`define LIT_OFS_LIMIT    8'h5f
`define ACC_HI_SPLIT     8'h60
`define ACC_BANK_LO      4'h0
`define ACC_BANK_HI      4'hf
// ---------------------------------------------------------------
// arithmetic constants
// ---------------------------------------------------------------
`define DEC_ONE          8'h01
`define BCD_NINE         4'h9
`define BCD_SIX          4'h6
// ---------------------------------------------------------------
// quarter-cycle one-hot states
// ---------------------------------------------------------------
`define Q_BITS           4
`define Q1_ST            4'h1
`define Q2_ST            4'h2
`define Q3_ST            4'h4
`define Q4_ST            4'h8
`endif

// *** tb/dec_exec_chk.sv ***
// assertion checker for the decrement execution block
`timescale 1ns/100ps
module dec_exec_chk #(parameter ADDR_W = 12) (
    input logic              core_clk,         // core clock
    input logic              sys_rst,          // sync reset
    input logic [ADDR_W-1:0] mem_addr,         // operand address
    input logic              mem_rd,           // read strobe
    input logic              mem_wr,           // write strobe
    input logic [7:0]        mem_wdata,        // write data
    input logic              wreg_wr,          // working register strobe
    input logic              flags_wr,         // flag strobe
    input logic              carry_flag,       // carry
    input logic              digit_carry_flag, // digit carry
    input logic              negative_flag,    // negative
    input logic              overflow_flag,    // overflow
    input logic              zero_flag,        // zero
    input logic              busy              // sequencer busy
);
    // ----------------
    // sequences and checks
    // ----------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_fetch; mem_rd ##1 !mem_rd; endsequence
    sequence s_hold; $stable(mem_addr) [*3]; endsequence
    a_rd_pulse: assert property (mem_rd |-> s_fetch) else $error("read strobe too long");
    a_addr_hold: assert property (mem_rd |=> s_hold) else $error("address moved");
    a_write_slot: assert property (mem_rd |-> ##[3:4] flags_wr) else $error("no write slot");
    a_one_dest: assert property (mem_wr |-> flags_wr && !wreg_wr) else $error("two targets");
    a_busy_end: assert property (flags_wr |-> !busy) else $error("busy at write");
    a_zero_res: assert property (mem_wr |-> zero_flag == (mem_wdata == 8'h00))
        else $error("zero flag wrong");
    a_neg_res: assert property (mem_wr |-> negative_flag == mem_wdata[7])
        else $error("negative flag wrong");
    a_borrow_out: assert property (mem_wr |-> carry_flag == (mem_wdata != 8'hff))
        else $error("carry flag wrong");
    a_nib_borrow: assert property (mem_wr |-> digit_carry_flag == (mem_wdata[3:0] != 4'hf))
        else $error("digit carry wrong");
    a_ovf_res: assert property (mem_wr |-> overflow_flag == (mem_wdata == 8'h7f))
        else $error("overflow flag wrong");
endmodule
bind decrement_file_register_exec dec_exec_chk #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk         (core_clk),
    .sys_rst          (sys_rst),
    .mem_addr         (mem_addr),
    .mem_rd           (mem_rd),
    .mem_wr           (mem_wr),
    .mem_wdata        (mem_wdata),
    .wreg_wr          (wreg_wr),
    .flags_wr         (flags_wr),
    .carry_flag       (carry_flag),
    .digit_carry_flag (digit_carry_flag),
    .negative_flag    (negative_flag),
    .overflow_flag    (overflow_flag),
    .zero_flag        (zero_flag),
    .busy             (busy)
);

// *** tb/testbench.sv ***
// self-checking bench for the decrement execution block
`timescale 1ns/100ps
module testbench;
    logic        core_clk = 0, sys_rst = 1, instr_valid = 0, ext_instr_en = 0;
    logic        digit_carry_flag_in = 0, e_mw, e_ww;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  bank_selection_register = 4'h0;
    logic [11:0] index_base = 12'h000, mem_addr, e_addr;
    logic [7:0]  wreg_in = 8'h00, status_c_in = 8'h00, mem_rdata = 8'h00;
    logic [7:0]  mem_wdata, wreg_wdata, e_data;
    logic [4:0]  e_fl;
    logic        mem_rd, mem_wr, wreg_wr, flags_wr, carry_flag, digit_carry_flag;
    logic        negative_flag, overflow_flag, zero_flag, busy;
    int          mismatches = 0, cmp_count = 0;
    decrement_file_register_exec #(.ADDR_W(12)) dut_u (
        .core_clk                (core_clk),
        .sys_rst                 (sys_rst),
        .instr_valid             (instr_valid),
        .instr_word              (instr_word),
        .bank_selection_register (bank_selection_register),
        .ext_instr_en            (ext_instr_en),
        .index_base              (index_base),
        .wreg_in                 (wreg_in),
        .status_c_in             (status_c_in),
        .digit_carry_flag_in     (digit_carry_flag_in),
        .mem_rdata               (mem_rdata),
        .mem_addr                (mem_addr),
        .mem_rd                  (mem_rd),
        .mem_wr                  (mem_wr),
        .mem_wdata               (mem_wdata),
        .wreg_wr                 (wreg_wr),
        .wreg_wdata              (wreg_wdata),
        .flags_wr                (flags_wr),
        .carry_flag              (carry_flag),
        .digit_carry_flag        (digit_carry_flag),
        .negative_flag           (negative_flag),
        .overflow_flag           (overflow_flag),
        .zero_flag               (zero_flag),
        .busy                    (busy)
    );
    // ----------------
    // helpers
    // ----------------
    initial forever #2.5 core_clk = ~core_clk;
    task automatic chk(input [11:0] got, input [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // offer a word, drop valid once taken so it is not run twice
    task automatic run(input [15:0] w, input [7:0] rd);
        bit drop;
        drop = 0;
        {e_addr, e_fl, e_mw, e_ww, e_data} = 'x;
        @(posedge core_clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        mem_rdata <= rd;
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            if (drop) instr_valid <= 1'b0;
            #1;
            drop = drop | busy;
            if (mem_rd) e_addr = mem_addr;
            if (flags_wr) begin
                {e_mw, e_ww} = {mem_wr, wreg_wr};
                e_data = mem_wr ? mem_wdata : wreg_wdata;
                e_fl = {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag};
                break;
            end
        end
    endtask
    task automatic dec(input d, a, input [7:0] f, op, input [11:0] ea);
        logic [7:0] r;
        r = op - 8'h01;
        run({6'h01, d, a, f}, op);
        chk(e_mw, d);
        chk(e_ww, !d);
        chk(e_data, r);
        chk(e_addr, ea);
        chk(e_fl, {op != 0, op[3:0] != 0, r[7], op == 8'h80, r == 0});
    endtask
    task automatic adj(input [7:0] w, input c, nc, input [7:0] r, input co);
        @(posedge core_clk);
        wreg_in <= w;
        status_c_in <= {7'h00, c};
        digit_carry_flag_in <= nc;
        run(16'h0007, 8'h00);
        chk({e_ww, e_mw}, 2'b10);
        chk(e_data, r);
        chk(e_fl[4:3], {co, nc});
    endtask
    // ----------------
    // scenarios
    // ----------------
    task t_refuse;
        bit bad;
        bad = 0;
        instr_word <= 16'h1234;
        instr_valid <= 1'b1;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            // strobes stay low and the negative flag at its reset level while only refused words come
            bad = bad | busy | mem_rd | mem_wr | wreg_wr | flags_wr | negative_flag;
        end
        @(posedge core_clk) instr_valid <= 1'b0;
        chk(bad, 0);
        $display("refused opcode test done");
    endtask
    task t_banked;
        @(posedge core_clk) bank_selection_register <= 4'h5;
        dec(1, 1, 8'h33, 8'h01, 12'h533);
        dec(1, 1, 8'h07, 8'h00, 12'h507);
        $display("banked test done");
    endtask
    task t_access;
        dec(0, 0, 8'h10, 8'h80, 12'h010);
        dec(0, 0, 8'h60, 8'h10, 12'hf60);
        dec(0, 0, 8'h5f, 8'h00, 12'h05f);
        $display("access bank test done");
    endtask
    task t_indexed;
        @(posedge core_clk) {ext_instr_en, index_base} <= {1'b1, 12'h200};
        dec(0, 0, 8'h5f, 8'h20, 12'h25f);
        dec(1, 0, 8'h60, 8'h20, 12'hf60);
        dec(1, 1, 8'h10, 8'h01, 12'h510);
        $display("indexed test done");
    endtask
    task t_adjust;
        adj(8'ha5, 0, 0, 8'h05, 1);
        adj(8'hce, 0, 0, 8'h34, 1);
        adj(8'h12, 0, 1, 8'h18, 0);
        adj(8'h12, 1, 0, 8'h72, 1);
        adj(8'h99, 0, 0, 8'h99, 0);
        $display("decimal adjust test done");
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_refuse();
        t_banked();
        t_access();
        t_indexed();
        t_adjust();
        wrap_up();
    end
    // the whole run needs under a thousand cycles; this is far beyond it
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
endmodule
